// ### verilog/lcfm_top.sv
// LF carrier control, fault record and readiness gating
`timescale 1ns/100ps
`default_nettype none
`include "lcfm_defs.svh"
module lcfm_top #(
    parameter int DIV = `LCFM_LF_DIV  // System clocks per LF period
) (
    // Clock and reset
    input  wire logic       MCLK_I,
    input  wire logic       RST_N_I,
    // Readiness pins, asynchronous
    input  wire logic       OSC_STABLE_I,
    input  wire logic       ANALOG_SUPPLY_OK_I,
    input  wire logic       DRIVER_SUPPLY_OK_I,
    // Commands from the serial front end, one-cycle pulses
    input  wire logic       SEL_DRIVER_I,
    input  wire logic       SPEED_SELECT_I,
    input  wire logic       GROUP_I,
    input  wire logic [1:0] INDEX_I,
    input  wire logic       SEL_CURRENT_I,
    input  wire logic [4:0] CURRENT_I,
    input  wire logic       CARRIER_I,
    input  wire logic [4:0] DURATION_I,
    input  wire logic       HALT_I,
    input  wire logic       FAULT_CLEAR_I,
    input  wire logic       STATUS_POLL_I,
    // Fault detectors, asynchronous
    input  wire logic       HEAT_I,
    input  wire logic       NO_RETURN_I,
    input  wire logic       SHUNT_OV_I,
    input  wire logic       HS_OC_I,
    input  wire logic       LS_OC_I,
    // Outputs
    output logic            CMD_READY_O,
    output logic            DRIVER_READY_O,
    output logic            DRIVE_EN_O,
    output logic            LF_PERIOD_O,
    output logic [4:0]      CURRENT_O,
    output logic            GROUP_O,
    output logic [1:0]      INDEX_O,
    output logic            SPEED_O,
    output logic [7:0]      FAULT_RECORD_O,
    output logic            FAULT_IRQ_O
);
    // ==================================================
    // State
    typedef struct packed {
        logic [2:0]         s1;        // First sync stage
        logic [2:0]         s2;        // Second sync stage
        logic [4:0]         f1;        // Fault first sync stage
        logic [4:0]         f2;        // Fault second sync stage
        lcfm_pkg::lcfm_state_t st;    // Sequencer state
        logic [6:0]         div;       // LF period divider
        logic [5:0]         per;       // Periods within unit
        logic [4:0]         units;     // Units remaining
        logic [4:0]         cur;       // Selected current step
        logic               grp;       // Driver group
        logic [1:0]         idx;       // Driver index
        logic               spd;       // Speed select
        logic [7:0]         rec;       // Fault record
        logic               irq;       // Interrupt request
        logic               rdy;       // Driver ready
    } lcfm_regs_t;

    lcfm_regs_t r;        // Registered state
    lcfm_regs_t next_r;   // Next state

    logic       osc_ok;   // Synchronised oscillator stable
    logic       ana_ok;   // Synchronised analog supply ready
    logic       drv_ok;   // Synchronised driver supply valid
    logic       alive;    // Block may operate
    logic       lf_tick;  // End of LF period
    logic [5:0] unit_len; // Periods per duration unit
    logic [3:0] flags;    // Fault flags detected
    logic       any_f;    // Any fault event this cycle
    logic       sel_ok;   // Setup commands may be taken

    assign osc_ok   = r.s2[0];
    assign ana_ok   = r.s2[1];
    assign drv_ok   = r.s2[2];
    assign alive    = osc_ok && ana_ok;                                       // R17 R20
    assign lf_tick  = (r.div == 7'(DIV - 1));                                 // R18 R25
    assign unit_len = r.spd ? `LCFM_UNIT_FAST : `LCFM_UNIT_NORMAL;            // R2 R23
    // No-return only counts while a coil is actually driven
    assign flags    = {r.f2[1] && DRIVE_EN_O, r.f2[2], r.f2[3], r.f2[4]};     // R12 R13 R14 R15
    assign any_f    = alive && (r.f2[0] || (|flags));
    // Setup needs only supplies and oscillator, not ready, so the channel can move off a held fault
    assign sel_ok   = alive && drv_ok;                                        // R21

    // ==================================================
    // Next-state logic
    always_comb begin
        next_r = r;
        // Two-stage synchronisers for the readiness and fault pin inputs
        next_r.s1 = {DRIVER_SUPPLY_OK_I, ANALOG_SUPPLY_OK_I, OSC_STABLE_I};
        next_r.s2 = r.s1;
        next_r.f1 = {LS_OC_I, HS_OC_I, SHUNT_OV_I, NO_RETURN_I, HEAT_I};
        next_r.f2 = r.f1;
        // Free-running LF period divider
        next_r.div = lf_tick ? 7'h00 : 7'(r.div + 7'h01);                     // R25
        if (alive) begin
            // Ready flag follows driver supply; clear restores it
            if (!drv_ok) begin
                next_r.rdy = 1'b0;                                            // R21
            end else if (FAULT_CLEAR_I) begin
                next_r.rdy = 1'b1;                                            // R22
            end else if (r.rec == 8'h00) begin
                next_r.rdy = 1'b1;                                            // R21
            end
            // Setup commands refused while the driver supply is low
            if (sel_ok && SEL_DRIVER_I) begin
                next_r.grp = GROUP_I;
                next_r.idx = INDEX_I;
                next_r.spd = SPEED_SELECT_I;                                  // R23
            end
            if (sel_ok && SEL_CURRENT_I) begin
                next_r.cur = CURRENT_I;                                       // R1
            end
            // Carrier sequencer
            unique case (r.st)
                lcfm_pkg::ST_IDLE: begin
                    if (CMD_READY_O && CARRIER_I) begin
                        next_r.per   = 6'h00;
                        next_r.units = DURATION_I;                            // R3
                        next_r.st    = (DURATION_I == 5'h00) ?
                                       lcfm_pkg::ST_ENDLESS :                 // R4
                                       lcfm_pkg::ST_TIMED;
                    end
                end
                lcfm_pkg::ST_TIMED: begin
                    if (HALT_I) begin
                        next_r.st = lcfm_pkg::ST_STOPPING;                    // R24
                    end else if (lf_tick) begin
                        // At or past the last period, so a speed change cannot overrun
                        if (r.per >= 6'(unit_len - 6'h01)) begin
                            next_r.per   = 6'h00;
                            next_r.units = 5'(r.units - 5'h01);               // R2
                            if (r.units == 5'h01) begin
                                next_r.st = lcfm_pkg::ST_IDLE;                // R25
                            end
                        end else begin
                            next_r.per = 6'(r.per + 6'h01);
                        end
                    end
                end
                lcfm_pkg::ST_ENDLESS: begin
                    if (HALT_I) begin
                        next_r.st = lcfm_pkg::ST_STOPPING;                    // R24
                    end
                end
                lcfm_pkg::ST_STOPPING: begin
                    if (lf_tick) begin
                        next_r.st = lcfm_pkg::ST_IDLE;                        // R24
                    end
                end
            endcase
            // Any stored fault kills the running carrier
            if (any_f || r.rec != 8'h00) begin
                next_r.st = lcfm_pkg::ST_IDLE;                                // R6
            end
            // Fault record; a new fault wins over a clear
            if (FAULT_CLEAR_I) begin
                next_r.rec = 8'h00;                                           // R8 R22
            end
            if (any_f) begin
                next_r.rec[`LCFM_FR_HEAT] = r.f2[0] |
                    (r.rec[`LCFM_FR_HEAT] && !FAULT_CLEAR_I);                 // R11
                next_r.rec[3:0] = (FAULT_CLEAR_I ? 4'h0 : r.rec[3:0]) | flags;
                next_r.rec[`LCFM_FR_GROUP] = r.grp;                           // R9 R10
                next_r.rec[`LCFM_FR_IDX_HI:`LCFM_FR_IDX_LO] = r.idx;          // R10
                next_r.rdy = 1'b0;
            end
            // Interrupt held until the status is polled
            if (STATUS_POLL_I) begin
                next_r.irq = 1'b0;
            end
            if (any_f) begin
                next_r.irq = 1'b1;                                            // R7
            end
        end else begin
            // Operation inhibited: carrier dropped, ready cleared
            next_r.st  = lcfm_pkg::ST_IDLE;                                   // R17 R20
            next_r.rdy = 1'b0;
        end
    end

    // ==================================================
    // State register
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            r       <= '0;
            r.st    <= lcfm_pkg::ST_IDLE;
            r.cur   <= `LCFM_CURRENT_RST;                                     // R1
            r.grp   <= `LCFM_GROUP_RST;
            r.idx   <= `LCFM_INDEX_RST;
        end else begin
            r <= next_r;
        end
    end

    // ==================================================
    // Outputs
    assign CMD_READY_O    = alive && r.rdy && drv_ok;                         // R21
    assign DRIVER_READY_O = r.rdy;
    assign DRIVE_EN_O     = (r.st != lcfm_pkg::ST_IDLE) && (r.rec == 8'h00);  // R6
    assign LF_PERIOD_O    = lf_tick;
    assign CURRENT_O      = r.cur;
    assign GROUP_O        = r.grp;
    assign INDEX_O        = r.idx;
    assign SPEED_O        = r.spd;
    assign FAULT_RECORD_O = r.rec;                                            // R9
    assign FAULT_IRQ_O    = r.irq;

    // ==================================================
    // Assertions
    // Fault record and interrupt
    a_fault_blocks_drive: assert property (@(posedge MCLK_I) disable iff (!RST_N_I) // R6
        (r.rec != 8'h00) |-> !DRIVE_EN_O)
        else $error("drive on with fault");
    a_irq_on_fault: assert property (@(posedge MCLK_I) disable iff (!RST_N_I) // R7
        any_f |=> FAULT_IRQ_O)
        else $error("irq missing after fault");
    a_irq_holds: assert property (@(posedge MCLK_I) disable iff (!RST_N_I) // R7
        FAULT_IRQ_O && !STATUS_POLL_I |=> FAULT_IRQ_O)
        else $error("irq dropped");
    a_poll_clears: assert property (@(posedge MCLK_I) disable iff (!RST_N_I) // R7
        STATUS_POLL_I && alive && !any_f |=> !FAULT_IRQ_O)
        else $error("irq kept after poll");
    a_record_sticky: assert property (@(posedge MCLK_I) disable iff (!RST_N_I) // R8
        (r.rec != 8'h00) && !FAULT_CLEAR_I |=> (r.rec != 8'h00))
        else $error("record lost");
    a_clear_empties: assert property (@(posedge MCLK_I) disable iff (!RST_N_I) // R22
        FAULT_CLEAR_I && alive && !any_f |=> FAULT_RECORD_O == 8'h00)
        else $error("record not cleared");
    a_clear_ready: assert property (@(posedge MCLK_I) disable iff (!RST_N_I) // R22
        FAULT_CLEAR_I && alive && drv_ok && !any_f |=> DRIVER_READY_O)
        else $error("ready not restored");
    a_record_driver: assert property (@(posedge MCLK_I) disable iff (!RST_N_I) // R10
        any_f |=> FAULT_RECORD_O[7:5] == $past({r.grp, r.idx}))
        else $error("wrong driver captured");
    a_heat_flag: assert property (@(posedge MCLK_I) disable iff (!RST_N_I) // R11
        any_f && r.f2[0] |=> FAULT_RECORD_O[`LCFM_FR_HEAT])
        else $error("heat bit missing");
    a_noret_flag: assert property (@(posedge MCLK_I) disable iff (!RST_N_I) // R12
        any_f && r.f2[1] && DRIVE_EN_O |=> FAULT_RECORD_O[`LCFM_FR_NORET])
        else $error("no return flag missing");
    a_shunt_flag: assert property (@(posedge MCLK_I) disable iff (!RST_N_I) // R13
        any_f && r.f2[2] |=> FAULT_RECORD_O[`LCFM_FR_SHUNT_OV])
        else $error("shunt flag missing");
    a_high_side_flag: assert property (@(posedge MCLK_I) disable iff (!RST_N_I) // R14
        any_f && r.f2[3] |=> FAULT_RECORD_O[`LCFM_FR_HS_OC])
        else $error("high side flag missing");
    a_low_side_flag: assert property (@(posedge MCLK_I) disable iff (!RST_N_I) // R15
        any_f && r.f2[4] |=> FAULT_RECORD_O[`LCFM_FR_LS_OC])
        else $error("low side flag missing");

    // Setup commands and readiness
    a_current_latch: assert property (@(posedge MCLK_I) disable iff (!RST_N_I) // R1
        sel_ok && SEL_CURRENT_I |=> CURRENT_O == $past(CURRENT_I))
        else $error("current not taken");
    a_current_refused: assert property (@(posedge MCLK_I) disable iff (!RST_N_I) // R21
        !sel_ok |=> CURRENT_O == $past(CURRENT_O))
        else $error("current changed while refused");
    a_driver_latch: assert property (@(posedge MCLK_I) disable iff (!RST_N_I) // R10
        sel_ok && SEL_DRIVER_I |=> {GROUP_O, INDEX_O} == $past({GROUP_I, INDEX_I}))
        else $error("driver not taken");
    a_speed_latch: assert property (@(posedge MCLK_I) disable iff (!RST_N_I) // R23
        sel_ok && SEL_DRIVER_I |=> SPEED_O == $past(SPEED_SELECT_I))
        else $error("speed not taken");
    a_low_supply: assert property (@(posedge MCLK_I) disable iff (!RST_N_I) // R21
        alive && !drv_ok |=> !DRIVER_READY_O)
        else $error("ready with low supply");
    a_inhibit_idle: assert property (@(posedge MCLK_I) disable iff (!RST_N_I) // R17 R20
        !alive |=> r.st == lcfm_pkg::ST_IDLE)
        else $error("ran while inhibited");

    // Carrier sequencer
    a_endless_start: assert property (@(posedge MCLK_I) disable iff (!RST_N_I) // R4
        r.st == lcfm_pkg::ST_IDLE && CMD_READY_O && CARRIER_I && DURATION_I == 5'h00 && !any_f
        |=> r.st == lcfm_pkg::ST_ENDLESS)
        else $error("endless not started");
    a_endless_holds: assert property (@(posedge MCLK_I) disable iff (!RST_N_I) // R4
        r.st == lcfm_pkg::ST_ENDLESS && !HALT_I && alive && !any_f && r.rec == 8'h00
        |=> r.st == lcfm_pkg::ST_ENDLESS)
        else $error("endless carrier ended");
    a_timed_start: assert property (@(posedge MCLK_I) disable iff (!RST_N_I) // R3
        r.st == lcfm_pkg::ST_IDLE && CMD_READY_O && CARRIER_I && DURATION_I != 5'h00 && !any_f
        |=> r.st == lcfm_pkg::ST_TIMED && r.units == $past(DURATION_I))
        else $error("timed carrier not started");
    a_one_unit: assert property (@(posedge MCLK_I) disable iff (!RST_N_I) // R2
        r.st == lcfm_pkg::ST_TIMED && r.units == 5'h01 && r.per == 6'(unit_len - 6'h01)
        && lf_tick && !HALT_I && !any_f && r.rec == 8'h00 && alive
        |=> r.st == lcfm_pkg::ST_IDLE)
        else $error("burst overran");
    a_halt_enters: assert property (@(posedge MCLK_I) disable iff (!RST_N_I) // R24
        (r.st == lcfm_pkg::ST_TIMED || r.st == lcfm_pkg::ST_ENDLESS) && HALT_I && alive
        && !any_f && r.rec == 8'h00 |=> r.st == lcfm_pkg::ST_STOPPING)
        else $error("halt not taken");
    a_halt_at_period: assert property (@(posedge MCLK_I) disable iff (!RST_N_I) // R24
        r.st == lcfm_pkg::ST_STOPPING && !lf_tick |=> DRIVE_EN_O || r.rec != 8'h00 || !alive)
        else $error("stop before period end");
    a_halt_stops: assert property (@(posedge MCLK_I) disable iff (!RST_N_I) // R24
        r.st == lcfm_pkg::ST_STOPPING && lf_tick |=> !DRIVE_EN_O)
        else $error("drive kept after halt");

    // LF period divider
    a_period_wrap: assert property (@(posedge MCLK_I) disable iff (!RST_N_I) // R25
        lf_tick |=> r.div == 7'h00)
        else $error("divider did not wrap");
    a_period_count: assert property (@(posedge MCLK_I) disable iff (!RST_N_I) // R18
        !lf_tick |=> r.div == 7'($past(r.div) + 7'h01))
        else $error("divider skipped");
    a_lf_single: assert property (@(posedge MCLK_I) disable iff (!RST_N_I) // R25
        LF_PERIOD_O |=> !LF_PERIOD_O)
        else $error("period pulse too long");
endmodule
`default_nettype wire

// ### inc/lcfm_defs.svh
// Constants for the LF carrier and fault monitor block
// Function
// [R1] Carrier uses last selected current, else default
// [R2] Duration unit is 32 or 22 LF periods
// [R3] Longest finite carrier is 31 units
// [R4] Zero duration starts an endless carrier
// [R5] Controller keeps endless carrier at low current
// [R6] Any stored fault disables all drivers
// [R7] Interrupt set on fault, held until poll
// [R8] Only fault clear or reset empties record
// [R9] Record bits: group, index, heat, four flags
// [R10] Record captures active driver group and index
// [R11] Heat bit from OR of sensors
// [R12] No return signal while driving sets flag
// [R13] Shunt overvoltage sets its flag
// [R14] High-side overcurrent sets its flag
// [R15] Low-side overcurrent sets its flag
// [R16] Controller changes channel before fault clear
// [R17] Nothing works until oscillator is stable
// [R18] LF carrier derived directly from system clock
// [R19] Controller keeps clock running outside power-down
// [R20] Nothing works until analog supply ready
// [R21] Low driver supply clears ready, refuses commands
// [R22] Fault clear empties record, sets ready if valid
// [R23] Speed select picks 32 or 22 periods
// [R24] Halt stops driver at LF period end
// [R25] LF period is system clock divided by 64
`ifndef LCFM_DEFS_SVH
`define LCFM_DEFS_SVH
// ==================================================
// Timing
`define LCFM_LF_DIV        7'd64
`define LCFM_UNIT_NORMAL   6'd32
`define LCFM_UNIT_FAST     6'd22
`define LCFM_DUR_MAX       5'd31
// ==================================================
// Reset values
`define LCFM_CURRENT_RST   5'h00
`define LCFM_GROUP_RST     1'b0
`define LCFM_INDEX_RST     2'h1
// ==================================================
// Fault record field positions
`define LCFM_FR_GROUP      7
`define LCFM_FR_IDX_HI     6
`define LCFM_FR_IDX_LO     5
`define LCFM_FR_HEAT       4
`define LCFM_FR_NORET      3
`define LCFM_FR_SHUNT_OV   2
`define LCFM_FR_HS_OC      1
`define LCFM_FR_LS_OC      0
`endif

// ### inc/lcfm_pkg.sv
// Types for the LF carrier and fault monitor block
package lcfm_pkg;
    // Carrier sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_TIMED,
        ST_ENDLESS,
        ST_STOPPING
    } lcfm_state_t;
endpackage

// ### bench/lcfm_mcu_model.sv
// Controller model that issues command pulses to the carrier and fault monitor
`timescale 1ns/100ps
`default_nettype none
module lcfm_mcu_model #(
    parameter logic [4:0] LOW_CUR_MAX = 5'h04  // Highest step allowed for endless carrier
) (
    // Clock, kept running for the whole run
    input  wire logic       clk_i,
    // Command pulses: select, current, carrier, halt, clear, poll
    output logic [5:0]      pulse_o,
    // Argument that qualifies the pulse
    output logic [4:0]      arg_o
);
    logic [4:0] cur = 5'h00;  // Last current step sent
    // ==================================================
    // Idle values at time zero
    initial begin
        pulse_o = 6'h00;
        arg_o = 5'h00;
    end
    // One command: raise after an edge, hold over the taking edge, then release
    task automatic issue(input int b, input logic [4:0] a);
        @(posedge clk_i);
        #1;
        pulse_o[b] = 1'b1;
        arg_o = a;
        @(posedge clk_i);
        #1;
        pulse_o = 6'h00;
        arg_o = ~a;  // Released argument shows no stale value
    endtask
    // Current step, remembered for the endless carrier guard
    task automatic current(input logic [4:0] c);
        cur = c;
        issue(1, c);
    endtask
    // Endless carrier only at a low current step
    task automatic endless();
        if (cur <= LOW_CUR_MAX) begin
            issue(2, 5'h00);
        end
    endtask
    // Move away from the faulty channel, then clear the record
    task automatic clear(input logic [4:0] other);
        issue(0, other);
        issue(4, 5'h00);
    endtask
endmodule
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench for the LF carrier and fault monitor
`timescale 1ns/100ps
`default_nettype none
`include "lcfm_defs.svh"
module testbench;
    // ==================================================
    // Signals
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       osc = 1'b0;
    logic       ana = 1'b0;
    logic       drv = 1'b0;
    logic [4:0] flt = 5'h00;  // Heat, no return, shunt, high side, low side
    logic [5:0] pulse;
    logic [4:0] arg;
    logic       cmd_rdy, drv_rdy, drive_en, lf_tick, grp_o, spd_o, irq;
    logic [4:0] cur_o;
    logic [1:0] idx_o;
    logic [7:0] rec;
    logic       grp;
    logic [1:0] idx;
    int         err_total = 0;
    int         samples_checked = 0;
    int         seed = 22;
    int         exp_cur = `LCFM_CURRENT_RST;  // Model: last current step taken
    logic [7:0] exp_rec_q[$];                 // Model: fault records still held
    int         k, n, b, c;
    always #2 clk = ~clk;
    // ==================================================
    // Design and controller model
    lcfm_top #(.DIV(4)) lcfm_top_i (
        .MCLK_I(clk), .RST_N_I(rst_n), .OSC_STABLE_I(osc), .ANALOG_SUPPLY_OK_I(ana),
        .DRIVER_SUPPLY_OK_I(drv), .SEL_DRIVER_I(pulse[0]), .SPEED_SELECT_I(arg[3]),
        .GROUP_I(arg[2]), .INDEX_I(arg[1:0]), .SEL_CURRENT_I(pulse[1]), .CURRENT_I(arg),
        .CARRIER_I(pulse[2]), .DURATION_I(arg), .HALT_I(pulse[3]), .FAULT_CLEAR_I(pulse[4]),
        .STATUS_POLL_I(pulse[5]), .HEAT_I(flt[4]), .NO_RETURN_I(flt[3]), .SHUNT_OV_I(flt[2]),
        .HS_OC_I(flt[1]), .LS_OC_I(flt[0]), .CMD_READY_O(cmd_rdy), .DRIVER_READY_O(drv_rdy),
        .DRIVE_EN_O(drive_en), .LF_PERIOD_O(lf_tick), .CURRENT_O(cur_o), .GROUP_O(grp_o),
        .INDEX_O(idx_o), .SPEED_O(spd_o), .FAULT_RECORD_O(rec), .FAULT_IRQ_O(irq));
    lcfm_mcu_model lcfm_mcu_model_i (.clk_i(clk), .pulse_o(pulse), .arg_o(arg));
    // ==================================================
    // Helpers
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Timed carrier: count LF periods while the driver is on
    task automatic run_timed(input logic [4:0] dur, input logic spd);
        lcfm_mcu_model_i.issue(0, {1'b0, spd, 1'b0, 2'h1});
        check("speed", spd_o, spd);
        lcfm_mcu_model_i.issue(2, dur);
        check("drive on", drive_en, 1'b1);
        n = 0;
        for (k = 0; k < 5000 && drive_en === 1'b1; k++) begin
            n += (lf_tick === 1'b1);
            step();
        end
        check("carrier periods", n, dur * (spd ? `LCFM_UNIT_FAST : `LCFM_UNIT_NORMAL));
    endtask
    task automatic tally_and_finish();
        if (err_total == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Watchdog against a hang
    initial begin
        #200000;
        err_total++;
        tally_and_finish();
    end
    // ==================================================
    // Main sequence
    initial begin
        repeat (16) step();
        check("reset current", cur_o, exp_cur);
        check("reset index", {grp_o, idx_o}, 3'h1);
        rst_n = 1'b1;
        repeat (6) step();
        check("ready no osc", cmd_rdy, 1'b0);
        lcfm_mcu_model_i.issue(2, 5'h03);
        check("refused carrier", drive_en, 1'b0);
        osc = 1'b1;
        repeat (6) step();
        check("ready no analog", cmd_rdy, 1'b0);
        ana = 1'b1;
        drv = 1'b1;
        for (k = 0; k < 10 && cmd_rdy !== 1'b1; k++) step();
        check("driver ready", drv_rdy, 1'b1);
        c = $unsigned($random(seed)) % 20;
        lcfm_mcu_model_i.current(5'(c));
        exp_cur = c;
        check("current", cur_o, exp_cur);
        run_timed(5'h01, 1'b0);
        run_timed(5'h01, 1'b1);
        run_timed(5'(1 + $unsigned($random(seed)) % 4), 1'b0);
        run_timed(`LCFM_DUR_MAX, 1'b1);
        lcfm_mcu_model_i.current(5'h02);
        exp_cur = 2;
        lcfm_mcu_model_i.endless();
        repeat (300) step();
        check("endless on", drive_en, 1'b1);
        lcfm_mcu_model_i.issue(3, 5'h00);
        for (k = 0; k < 20 && lf_tick !== 1'b1; k++) begin
            check("halt waits", drive_en, 1'b1);
            step();
        end
        step();
        check("halt stop", drive_en, 1'b0);
        // Every fault source on a different channel
        for (b = 0; b < 5; b++) begin
            grp = b[0];
            idx = 2'(b % 3 + 1);
            lcfm_mcu_model_i.issue(0, {2'b00, grp, idx});
            check("channel", {grp_o, idx_o}, {grp, idx});
            lcfm_mcu_model_i.endless();
            flt[b] = 1'b1;
            exp_rec_q.push_back({grp, idx, 5'(1 << b)});
            for (k = 0; k < 10 && irq !== 1'b1; k++) step();
            check("record", rec, exp_rec_q[0]);
            check("drive off", drive_en, 1'b0);
            flt[b] = 1'b0;
            repeat (5) step();
            check("irq held", irq, 1'b1);
            lcfm_mcu_model_i.issue(5, 5'h00);
            check("irq polled", irq, 1'b0);
            check("record kept", rec, exp_rec_q[0]);
            lcfm_mcu_model_i.clear({2'b00, ~grp, idx});
            check("channel moved", {grp_o, idx_o}, {~grp, idx});
            exp_rec_q.delete();
            check("record clear", rec, 8'h00);
            for (k = 0; k < 10 && drv_rdy !== 1'b1; k++) step();
            check("ready back", drv_rdy, 1'b1);
        end
        drv = 1'b0;
        for (k = 0; k < 10 && drv_rdy !== 1'b0; k++) step();
        check("ready low", drv_rdy, 1'b0);
        lcfm_mcu_model_i.issue(2, 5'h01);
        check("low supply refuse", drive_en, 1'b0);
        lcfm_mcu_model_i.issue(1, 5'h07);
        check("current refused", cur_o, exp_cur);
        drv = 1'b1;
        for (k = 0; k < 10 && drv_rdy !== 1'b1; k++) step();
        check("ready again", drv_rdy, 1'b1);
        tally_and_finish();
    end
endmodule
`default_nettype wire
